// >>> logic/bridge_primary.sv
// primary-side bridge: status, key port, mailboxes and two word fifos
// assumes the secondary-side signals are synchronous to clock_in
// Notes on behaviour
// - status bit 15 reads 1 while the secondary is held in reset
// - status bit 14 reads 1 after a secondary watchdog reset
// - watchdog flag set by hardware, cleared by software or power-on reset only
// - status bits 13-12 report the secondary low-power state
// - status bit 11 reports a program-memory verify error
// - status bit 10 mirrors the secondary panel-two-active flag
// - status bit 9 reads 1 while the secondary requests an interrupt
// - status bit 8 shows secondary acknowledge; ack without request is an error
// - status bit 7 reads 1 while the secondary is in debug mode
// - key port watches its low byte on writes and always reads zero
// - mailbox words with direction 1 are read-only, carrying secondary data
// - mailbox words with direction 0 are primary read/write, reset to zero
// - outbound enable 1 enables the fifo, 0 disables and empties it
// - outbound overflow and underflow are sticky until the enable is cleared
// - outbound full reads 1 when no free location remains
// - outbound empty reads 1 when drained or disabled, until a new write
// - inbound enable 1 enables the fifo, 0 disables and empties it
// - inbound overflow and underflow read 1 once detected
// - inbound full reads 1 when no free location remains
// - inbound empty resets to 1 and reads 0 while unread data remains
// - inbound data port gives the oldest word and each read consumes it
// - mailbox ready flag sets on a transmitter write, 0 when block disabled
// - secondary enable 0 holds the secondary in reset, 1 releases it
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps

module bridge_primary #(
  parameter int DEPTH = bridge_pkg::FIFO_DEPTH  // words in each fifo
) (
  input  wire logic                        clock_in,        // 100 MHz clock
  input  wire logic                        resetn_in,       // synchronous reset, low
  input  wire logic [7:0]                  address_in,      // avalon byte address
  input  wire logic                        read_in,         // avalon read
  input  wire logic                        write_in,        // avalon write
  input  wire logic [31:0]                 writedata_in,    // avalon write data
  input  wire logic [3:0]                  byteenable_in,   // avalon byte enables
  output logic [31:0]                      readdata_out,    // avalon read data
  output logic                             waitrequest_out, // avalon wait
  input  wire bridge_pkg::sec_status_type  sec_status_in,   // secondary state
  input  wire logic [15:0]                 mbx_dir_in,      // mailbox direction config
  input  wire logic [7:0]                  ready_en_in,     // handshake block enables
  input  wire logic                        sec_mbx_write_in,// secondary mailbox write
  input  wire logic                        sec_mbx_read_in, // secondary mailbox read
  input  wire logic [3:0]                  sec_mbx_index_in,// secondary mailbox index
  input  wire logic [15:0]                 sec_mbx_data_in, // secondary mailbox data
  output logic [255:0]                     mbx_data_out,    // all mailbox words
  output logic [7:0]                       mbx_ready_out,   // mailbox ready flags
  input  wire logic                        out_pop_in,      // secondary takes a word
  output logic [15:0]                      out_data_out,    // outbound head word
  output logic                             out_valid_out,   // outbound not empty, low in the cycle its last word pops
  input  wire logic                        in_push_in,      // secondary offers a word
  input  wire logic [15:0]                 in_data_in,      // inbound word
  output logic                             in_ready_out,    // inbound has room
  output logic                             sec_enable_out,  // releases the secondary
  output logic                             p2s_request_out, // primary request to secondary
  output logic                             protocol_error_out, // ack with no request
  output logic                             key_strobe_out,  // key byte written
  output logic [7:0]                       key_data_out     // key byte value
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  // -------------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------------
  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic [31:0] read_word;
  wire         request   = read_in | write_in;
  wire         wr_accept = write_in & ack_reg;
  wire         rd_accept = read_in & ack_reg;
  wire         is_mbx    = (address_in >= bridge_pkg::ADDR_MBX_BASE) &&
                           (address_in <= bridge_pkg::ADDR_MBX_LAST);
  wire [3:0]   mbx_index = address_in[5:2];

  // one wait cycle; read data registers on the edge that ends it, every side effect on the edge after
  assign waitrequest_out = request & ~ack_reg;
  assign readdata_out    = readdata_reg;

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg      <= request & ~ack_reg;
      readdata_reg <= (read_in & ~ack_reg) ? read_word : 32'h0000_0000;
    end
  end

  // -------------------------------------------------------------------
  // control and watchdog flag
  // -------------------------------------------------------------------
  logic sec_enable_reg;
  logic p2s_req_reg;
  logic wdt_flag_reg;
  logic proto_err_reg;
  wire  ctrl_wr   = wr_accept && (address_in == bridge_pkg::ADDR_CONTROL);
  wire  status_wr = wr_accept && (address_in == bridge_pkg::ADDR_STATUS);
  wire  wdt_clear = status_wr && !writedata_in[bridge_pkg::BIT_WDT_RESET];

  // control bits; the watchdog flag sets over a software clear
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sec_enable_reg <= 1'b0;
      p2s_req_reg    <= 1'b0;
      wdt_flag_reg   <= 1'b0;
      proto_err_reg  <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        sec_enable_reg <= writedata_in[bridge_pkg::BIT_SEC_ENABLE];
        p2s_req_reg    <= writedata_in[bridge_pkg::BIT_P2S_REQ];
      end
      if (sec_status_in.wdt_reset_event)
        wdt_flag_reg <= 1'b1;
      else if (wdt_clear)
        wdt_flag_reg <= 1'b0;
      proto_err_reg <= sec_status_in.acknowledge & ~p2s_req_reg;
    end
  end

  assign sec_enable_out     = sec_enable_reg;
  assign p2s_request_out    = p2s_req_reg;
  assign protocol_error_out = proto_err_reg;

  // secondary is in reset while disabled or while it reports reset
  wire       in_reset_now = sec_status_in.in_reset | ~sec_enable_reg;
  wire [15:0] status_word = {in_reset_now,
                             wdt_flag_reg,
                             sec_status_in.power_state,
                             sec_status_in.verify_error,
                             sec_status_in.panel_two,
                             sec_status_in.request,
                             sec_status_in.acknowledge,
                             sec_status_in.debug,
                             7'h00};
  wire [15:0] control_word = {sec_enable_reg, 5'h00, p2s_req_reg, 9'h000};

  // -------------------------------------------------------------------
  // key port: not readable, write strobe plus the last written byte
  // -------------------------------------------------------------------
  logic       key_strobe_reg;
  logic [7:0] key_data_reg;
  wire        key_wr = wr_accept && (address_in == bridge_pkg::ADDR_KEY);

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      key_strobe_reg <= 1'b0;
      key_data_reg   <= 8'h00;
    end else begin
      key_strobe_reg <= key_wr;
      if (key_wr)
        key_data_reg <= writedata_in[7:0];
    end
  end

  assign key_strobe_out = key_strobe_reg;
  assign key_data_out   = key_data_reg;

  // -------------------------------------------------------------------
  // mailboxes and ready flags
  // -------------------------------------------------------------------
  logic [15:0] mbx_reg [bridge_pkg::MBX_COUNT];
  logic [7:0]  ready_reg;
  wire         mbx_pri_wr = wr_accept && is_mbx && !mbx_dir_in[mbx_index];
  wire         mbx_sec_wr = sec_mbx_write_in && mbx_dir_in[sec_mbx_index_in];
  wire         mbx_pri_rd = rd_accept && is_mbx;

  // byte-lane merge of a primary write into a mailbox word
  function automatic logic [15:0] merge(input logic [15:0] old_word,
                                        input logic [15:0] new_word,
                                        input logic [1:0]  lanes);
    merge = {lanes[1] ? new_word[15:8] : old_word[15:8],
             lanes[0] ? new_word[7:0]  : old_word[7:0]};
  endfunction : merge

  // mailbox storage; the direction bit picks the only writer
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < bridge_pkg::MBX_COUNT; i++)
        mbx_reg[i] <= 16'h0000;
    end else if (mbx_pri_wr) begin
      mbx_reg[mbx_index] <= merge(mbx_reg[mbx_index], writedata_in[15:0],
                                  byteenable_in[1:0]);
    end else if (mbx_sec_wr) begin
      mbx_reg[sec_mbx_index_in] <= sec_mbx_data_in;
    end
  end

  // ready flag k guards mailbox k; transmitter write sets, receiver read clears
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ready_reg <= 8'h00;
    end else begin
      for (int k = 0; k < bridge_pkg::READY_COUNT; k++) begin
        if (!ready_en_in[k])
          ready_reg[k] <= 1'b0;
        else if ((mbx_pri_wr && mbx_index == 4'(k)) ||
                 (mbx_sec_wr && sec_mbx_index_in == 4'(k)))
          ready_reg[k] <= 1'b1;
        else if ((mbx_pri_rd && mbx_index == 4'(k) && mbx_dir_in[k]) ||
                 (sec_mbx_read_in && sec_mbx_index_in == 4'(k) && !mbx_dir_in[k]))
          ready_reg[k] <= 1'b0;
      end
    end
  end

  assign mbx_ready_out = ready_reg;
  always_comb begin
    for (int i = 0; i < bridge_pkg::MBX_COUNT; i++)
      mbx_data_out[i*16 +: 16] = mbx_reg[i];
  end

  // -------------------------------------------------------------------
  // fifos
  // -------------------------------------------------------------------
  // circular pointer advance
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] ptr);
    bump = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
  endfunction : bump

  logic [15:0]   out_mem [DEPTH];
  logic [PW-1:0] out_wr_reg, out_rd_reg;
  logic [CW-1:0] out_cnt_reg;
  logic          out_en_reg, out_ovf_reg, out_unf_reg;
  logic [15:0]   in_mem [DEPTH];
  logic [PW-1:0] in_wr_reg, in_rd_reg;
  logic [CW-1:0] in_cnt_reg;
  logic          in_en_reg, in_ovf_reg, in_unf_reg;
  logic [15:0]   out_head_reg;

  wire fifo_cs_wr  = wr_accept && (address_in == bridge_pkg::ADDR_FIFO_CS);
  // a disabling write empties the fifo on the same edge that drops the enable
  wire out_clear   = fifo_cs_wr && !writedata_in[bridge_pkg::BIT_OUT_EN];
  wire in_clear    = fifo_cs_wr && !writedata_in[bridge_pkg::BIT_IN_EN];
  wire out_wr_req  = wr_accept && (address_in == bridge_pkg::ADDR_OUT_DATA);
  wire in_rd_req   = rd_accept && (address_in == bridge_pkg::ADDR_IN_DATA);
  wire out_full    = out_cnt_reg == FULL_COUNT;
  wire out_empty   = out_cnt_reg == '0;
  wire in_full     = in_cnt_reg == FULL_COUNT;
  wire in_empty    = in_cnt_reg == '0;
  wire out_push    = out_en_reg & out_wr_req & ~out_full;
  wire out_pop     = out_en_reg & out_pop_in & ~out_empty;
  wire in_push     = in_en_reg & in_push_in & ~in_full;
  wire in_pop      = in_en_reg & in_rd_req & ~in_empty;

  // enables from software
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      out_en_reg <= 1'b0;
      in_en_reg  <= 1'b0;
    end else if (fifo_cs_wr) begin
      out_en_reg <= writedata_in[bridge_pkg::BIT_OUT_EN];
      in_en_reg  <= writedata_in[bridge_pkg::BIT_IN_EN];
    end
  end

  // outbound fifo: primary writes, secondary drains
  always_ff @(posedge clock_in) begin
    if (!resetn_in || !out_en_reg || out_clear) begin
      out_wr_reg  <= '0;
      out_rd_reg  <= '0;
      out_cnt_reg <= '0;
      out_ovf_reg <= 1'b0;
      out_unf_reg <= 1'b0;
    end else begin
      if (out_push) begin
        out_mem[out_wr_reg] <= writedata_in[15:0];
        out_wr_reg          <= bump(out_wr_reg);
      end
      if (out_pop)
        out_rd_reg <= bump(out_rd_reg);
      out_cnt_reg <= out_cnt_reg + CW'(out_push) - CW'(out_pop);
      if (out_wr_req && out_full)
        out_ovf_reg <= 1'b1;
      if (out_pop_in && out_empty)
        out_unf_reg <= 1'b1;
    end
  end

  // inbound fifo: secondary fills, primary reads
  always_ff @(posedge clock_in) begin
    if (!resetn_in || !in_en_reg || in_clear) begin
      in_wr_reg  <= '0;
      in_rd_reg  <= '0;
      in_cnt_reg <= '0;
      in_ovf_reg <= 1'b0;
      in_unf_reg <= 1'b0;
    end else begin
      if (in_push) begin
        in_mem[in_wr_reg] <= in_data_in;
        in_wr_reg         <= bump(in_wr_reg);
      end
      if (in_pop)
        in_rd_reg <= bump(in_rd_reg);
      in_cnt_reg <= in_cnt_reg + CW'(in_push) - CW'(in_pop);
      if (in_push_in && in_full)
        in_ovf_reg <= 1'b1;
      if (in_rd_req && in_empty)
        in_unf_reg <= 1'b1;
    end
  end

  // registered head word toward the secondary
  always_ff @(posedge clock_in) begin
    if (!resetn_in)
      out_head_reg <= 16'h0000;
    else
      out_head_reg <= out_mem[out_pop ? bump(out_rd_reg) : out_rd_reg];
  end

  assign out_data_out  = out_head_reg;
  assign out_valid_out = out_en_reg & ~out_empty & ~(out_pop && out_cnt_reg == CW'(1));
  assign in_ready_out  = in_en_reg & ~in_full;

  wire [15:0] fifo_cs_word = {out_en_reg, 3'h0, out_ovf_reg, out_unf_reg,
                              out_full, out_empty,
                              in_en_reg, 3'h0, in_ovf_reg, in_unf_reg,
                              in_full, in_empty};
  wire [15:0] in_head = in_empty ? 16'h0000 : in_mem[in_rd_reg];

  // -------------------------------------------------------------------
  // read mux; unmapped and write-only addresses read zero
  // -------------------------------------------------------------------
  always_comb begin
    read_word = 32'h0000_0000;
    if (is_mbx)
      read_word = {16'h0000, mbx_reg[mbx_index]};
    else
      unique case (address_in)
        bridge_pkg::ADDR_STATUS:    read_word = {16'h0000, status_word};
        bridge_pkg::ADDR_MBX_READY: read_word = {24'h000000, ready_reg};
        bridge_pkg::ADDR_FIFO_CS:   read_word = {16'h0000, fifo_cs_word};
        bridge_pkg::ADDR_IN_DATA:   read_word = {16'h0000, in_head};
        bridge_pkg::ADDR_CONTROL:   read_word = {16'h0000, control_word};
        default:                    read_word = 32'h0000_0000;
      endcase
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  AST_RESET_FLAG: assert property (@(posedge clock_in) disable iff (!resetn_in)
    !sec_enable_reg |-> status_word[bridge_pkg::BIT_IN_RESET])
    else $error("reset flag low while secondary disabled");
  AST_WDT_SET: assert property (@(posedge clock_in) disable iff (!resetn_in)
    sec_status_in.wdt_reset_event |=> wdt_flag_reg)
    else $error("watchdog flag not set");
  AST_WDT_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)
    wdt_flag_reg && !wdt_clear |=> wdt_flag_reg)
    else $error("watchdog flag lost without clear");
  AST_PROTO: assert property (@(posedge clock_in) disable iff (!resetn_in)
    sec_status_in.acknowledge && !p2s_req_reg |=> protocol_error_out)
    else $error("protocol error missed");
  AST_KEY_ZERO: assert property (@(posedge clock_in) disable iff (!resetn_in)
    rd_accept && address_in == bridge_pkg::ADDR_KEY |-> readdata_out == 32'h0)
    else $error("key port read nonzero");
  AST_MBX_RO: assert property (@(posedge clock_in) disable iff (!resetn_in)
    wr_accept && is_mbx && mbx_dir_in[mbx_index] && !mbx_sec_wr
    |=> mbx_reg[$past(mbx_index)] == $past(mbx_reg[mbx_index]))
    else $error("read-only mailbox changed");
  AST_OUT_DISABLE: assert property (@(posedge clock_in) disable iff (!resetn_in)
    !out_en_reg |-> out_empty && !out_ovf_reg && !out_unf_reg)
    else $error("disabled outbound fifo not initial");
  AST_OUT_OVF: assert property (@(posedge clock_in) disable iff (!resetn_in)
    out_en_reg && out_wr_req && out_full && !fifo_cs_wr |=> out_ovf_reg)
    else $error("outbound overflow missed");
  AST_IN_COUNT: assert property (@(posedge clock_in) disable iff (!resetn_in)
    in_push && !in_pop && !fifo_cs_wr |=> !in_empty ##0
    in_cnt_reg == $past(in_cnt_reg) + CW'(1))
    else $error("inbound count wrong");
  AST_WAIT: assert property (@(posedge clock_in) disable iff (!resetn_in)
    request && !ack_reg |=> !waitrequest_out)
    else $error("bus answer late");

  COV_OUT_FULL: cover property (@(posedge clock_in) disable iff (!resetn_in) out_full);
  COV_IN_READ: cover property (@(posedge clock_in) disable iff (!resetn_in) in_pop);
  COV_WDT: cover property (@(posedge clock_in) disable iff (!resetn_in) wdt_clear);
  COV_MBX: cover property (@(posedge clock_in) disable iff (!resetn_in) mbx_sec_wr);

endmodule : bridge_primary

// >>> logic/bridge_pkg.sv
// package for the primary-side inter-processor bridge
// assumes one 100 MHz clock shared with the secondary-facing logic
package bridge_pkg;

  // register byte addresses on the avalon slave
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_KEY       = 8'h04;
  localparam logic [7:0] ADDR_MBX_READY = 8'h08;
  localparam logic [7:0] ADDR_FIFO_CS   = 8'h0c;
  localparam logic [7:0] ADDR_IN_DATA   = 8'h10;
  localparam logic [7:0] ADDR_OUT_DATA  = 8'h14;
  localparam logic [7:0] ADDR_CONTROL   = 8'h18;
  localparam logic [7:0] ADDR_MBX_BASE  = 8'h40;
  localparam logic [7:0] ADDR_MBX_LAST  = 8'h7c;

  // status register fields
  localparam int BIT_IN_RESET   = 15;
  localparam int BIT_WDT_RESET  = 14;
  localparam int BIT_POWER_HI   = 13;
  localparam int BIT_POWER_LO   = 12;
  localparam int BIT_VERIFY_ERR = 11;
  localparam int BIT_PANEL_TWO  = 10;
  localparam int BIT_S2P_REQ    = 9;
  localparam int BIT_ACK        = 8;
  localparam int BIT_DEBUG      = 7;

  // fifo control/status fields
  localparam int BIT_OUT_EN     = 15;
  localparam int BIT_OUT_OVF    = 11;
  localparam int BIT_OUT_UNF    = 10;
  localparam int BIT_OUT_FULL   = 9;
  localparam int BIT_OUT_EMPTY  = 8;
  localparam int BIT_IN_EN      = 7;
  localparam int BIT_IN_OVF     = 3;
  localparam int BIT_IN_UNF     = 2;
  localparam int BIT_IN_FULL    = 1;
  localparam int BIT_IN_EMPTY   = 0;

  // control register fields
  localparam int BIT_SEC_ENABLE = 15;
  localparam int BIT_P2S_REQ    = 9;

  localparam int MBX_COUNT      = 16;
  localparam int READY_COUNT    = 8;
  localparam int WORD_WIDTH     = 16;
  localparam int FIFO_DEPTH     = 16;

  // status reported by the secondary subsystem
  typedef struct packed {
    logic       in_reset;        // secondary held in reset
    logic       wdt_reset_event; // one-cycle pulse on a watchdog reset
    logic [1:0] power_state;     // 11 deep sleep 10 sleep 01 idle 00 run
    logic       verify_error;    // program verify failed
    logic       panel_two;       // panel-two-active flag of the secondary
    logic       request;         // secondary-to-primary request
    logic       acknowledge;     // secondary acknowledge
    logic       debug;           // secondary in debug mode
  } sec_status_type;

endpackage : bridge_pkg

// >>> dv/secondary_model.sv
// model of the secondary subsystem on the far side of the bridge
// assumes it shares clock_in with the bridge; the bench calls its tasks
`timescale 1ns/1ps
module secondary_model (
  input  wire logic                  clock_in,      // shared clock
  input  wire logic [15:0]           head_in,       // outbound head word
  output bridge_pkg::sec_status_type status_out,    // reported state
  output logic                       push_out,      // inbound push pulse
  output logic                       pop_out,       // outbound pop pulse
  output logic                       mbx_write_out, // mailbox write pulse
  output logic [15:0]                data_out       // pushed or mailbox word
);
  // quiet outputs from time zero
  initial begin
    status_out = '0;
    push_out = 1'b0;
    pop_out = 1'b0;
    mbx_write_out = 1'b0;
    data_out = 16'h0000;
  end
  // level state reported to the primary
  task set_status(input bridge_pkg::sec_status_type s);
    @(posedge clock_in);
    status_out <= s;
  endtask : set_status
  // one pulse: 0 push, 1 pop, 2 mailbox write, 3 watchdog reset event
  task pulse(input int k, input logic [15:0] d, output logic [15:0] h);
    @(posedge clock_in);
    push_out <= (k == 0);
    pop_out <= (k == 1);
    mbx_write_out <= (k == 2);
    status_out.wdt_reset_event <= (k == 3);
    data_out <= d;
    @(posedge clock_in);
    h = head_in;
    push_out <= 1'b0;
    pop_out <= 1'b0;
    mbx_write_out <= 1'b0;
    status_out.wdt_reset_event <= 1'b0;
    data_out <= ~d; // released word never shows the old value
  endtask : pulse
endmodule : secondary_model

// >>> dv/testbench.sv
// self-checking bench for the primary-side bridge
// assumes bridge_primary and secondary_model are compiled before it
`timescale 1ns/1ps
module testbench;
  localparam int D = 4; // shortened fifo depth
  logic                       clock_in = 1'b0;
  logic                       resetn_in = 1'b0;
  logic                       rd_en = 1'b0;
  logic                       wr_en = 1'b0;
  logic [7:0]                 address = 8'h00;
  logic [31:0]                wdata = 32'h0;
  logic [31:0]                rdata;
  logic [31:0]                q;
  logic                       waitreq;
  logic                       perr;
  logic                       sen;
  logic                       preq;
  logic                       ov;
  logic                       ir;
  logic [7:0]                 kd;
  logic [7:0]                 ren = 8'hff;
  logic                       pop;
  logic                       push;
  logic                       mw;
  logic [15:0]                head;
  logic [15:0]                sdata;
  logic [15:0]                h;
  bridge_pkg::sec_status_type stat;
  int                         err_count = 0;
  int                         check_count = 0;

  always #5 clock_in = ~clock_in;

  bridge_primary #(.DEPTH(D)) u_dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .address_in(address), .read_in(rd_en), .write_in(wr_en), .writedata_in(wdata),
    .byteenable_in(4'hf), .readdata_out(rdata), .waitrequest_out(waitreq),
    .sec_status_in(stat), .mbx_dir_in(16'h0001), .ready_en_in(ren),
    .sec_mbx_write_in(mw), .sec_mbx_read_in(1'b0), .sec_mbx_index_in(4'h0),
    .sec_mbx_data_in(sdata), .mbx_data_out(), .mbx_ready_out(), .out_pop_in(pop),
    .out_data_out(head), .out_valid_out(ov), .in_push_in(push), .in_data_in(sdata),
    .in_ready_out(ir), .sec_enable_out(sen), .p2s_request_out(preq),
    .protocol_error_out(perr), .key_strobe_out(), .key_data_out(kd));

  secondary_model u_sec (.clock_in(clock_in), .head_in(head), .status_out(stat),
    .push_out(push), .pop_out(pop), .mbx_write_out(mw), .data_out(sdata));

  // ----------------------------------------
  // bus access and comparison tasks
  // ----------------------------------------
  task chk(input logic [7:0] a, input logic [15:0] e, input logic [31:0] g);
    check_count++;
    if (g !== {16'h0000, e}) begin
      err_count++;
      $display("ERROR reg %h expected %h seen %h", a, e, g);
    end
  endtask : chk
  // avalon cycle held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    rd_en <= ~w;
    wr_en <= w;
    address <= a;
    wdata <= {16'h0000, d};
    do @(posedge clock_in); while (waitreq !== 1'b0);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus
  task rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(a, e, q);
  endtask : rd
  task wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // watchdog: the tests need about two hundred cycles
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd(8'h00, 16'h8000);
    rd(8'h0c, 16'h0101);
    wr(8'h04, 16'h0055);
    @(posedge clock_in);
    chk(8'hfe, 16'h0055, {24'h0, kd});
    rd(8'h04, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(8'h18, 16'h8000);
    u_sec.set_status({1'b0, 1'b0, 2'b10, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1});
    chk(8'hfd, 16'h0001, {31'h0, sen});
    rd(8'h00, 16'h2e80);
    u_sec.set_status({1'b0, 1'b0, 2'b11, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    u_sec.pulse(3, 16'h0000, h);
    rd(8'h00, 16'h7100);
    chk(8'hff, 16'h0001, {31'h0, perr});
    wr(8'h18, 16'h8200);
    rd(8'h18, 16'h8200);
    chk(8'hfc, 16'h0001, {31'h0, preq});
    chk(8'hff, 16'h0000, {31'h0, perr});
    wr(8'h18, 16'h0000);
    rd(8'h00, 16'hf100);
    chk(8'hfd, 16'h0000, {31'h0, sen});
    wr(8'h00, 16'h0000);
    rd(8'h00, 16'hb100);
    // mailbox 0 is written by the secondary, mailbox 1 by the primary
    wr(8'h40, 16'h1234);
    rd(8'h40, 16'h0000);
    u_sec.pulse(2, 16'hbeef, h);
    wr(8'h44, 16'h5a5a);
    rd(8'h08, 16'h0003);
    ren <= 8'hfd;
    rd(8'h08, 16'h0001);
    rd(8'h40, 16'hbeef);
    rd(8'h44, 16'h5a5a);
    rd(8'h48, 16'h0000);
    // outbound fifo filled past full, drained past empty
    wr(8'h0c, 16'h8080);
    rd(8'h0c, 16'h8181);
    chk(8'hfb, 16'h0001, {31'h0, ir});
    for (int i = 0; i < D; i++) wr(8'h14, 16'h0a00 + 16'(i));
    rd(8'h0c, 16'h8281);
    chk(8'hfa, 16'h0001, {31'h0, ov});
    wr(8'h14, 16'hffff);
    rd(8'h0c, 16'h8a81);
    for (int i = 0; i < D; i++) begin
      u_sec.pulse(1, 16'h0000, h);
      chk(8'h14, 16'h0a00 + 16'(i), {16'h0000, h});
    end
    rd(8'h0c, 16'h8981);
    chk(8'hfa, 16'h0000, {31'h0, ov});
    u_sec.pulse(1, 16'h0000, h);
    rd(8'h0c, 16'h8d81);
    wr(8'h0c, 16'h0080);
    rd(8'h0c, 16'h0181);
    // inbound fifo filled past full, drained past empty
    for (int i = 0; i < D; i++) u_sec.pulse(0, 16'h00c0 + 16'(i), h);
    rd(8'h0c, 16'h0182);
    chk(8'hfb, 16'h0000, {31'h0, ir});
    u_sec.pulse(0, 16'h0001, h);
    rd(8'h0c, 16'h018a);
    for (int i = 0; i < D; i++) rd(8'h10, 16'h00c0 + 16'(i));
    rd(8'h10, 16'h0000);
    rd(8'h0c, 16'h018d);
    wr(8'h0c, 16'h0000);
    rd(8'h0c, 16'h0101);
    tally_and_finish();
  end
endmodule : testbench
